//--- rtl/fdcs_drive_if.sv
// bundle between register logic, spin-up timer and drive generator
// assumes all three sit on core_clk
`timescale 1ns/10ps
interface fdcs_drive_if;
  logic [3:0] target;
  logic full_speed;
  logic [2:0] freq_code;
  logic [1:0] ramp_code;
  logic filt_en;
  logic drive;
  logic spin_start;
  logic spin_bypass;
  logic [2:0] spin_code;
  logic spin_active;
  modport ctrl (output target, full_speed, freq_code, ramp_code, filt_en,
                spin_start, spin_bypass, spin_code, input drive, spin_active);
  modport pwm (input target, full_speed, freq_code, ramp_code, filt_en,
               output drive);
  modport spin (input spin_start, spin_bypass, spin_code, output spin_active);
endinterface : fdcs_drive_if

//--- rtl/fdcs_pkg.sv
// shared constants, field layout and lookup functions for the fan drive block
// assumes one core clock; all figures derive from the clock rate here
package fdcs_pkg;
  // 25 MHz core clock, 40 ns period
  localparam int unsigned CLK_RATE_HZ = 32'h017d7840;
  localparam int unsigned CLK_PERIOD_NS = 32'h28;
  localparam int unsigned MS_PER_S = 32'h3e8;

  localparam logic [7:0] OFS_ALARM_TWO = 8'h03;
  localparam logic [7:0] OFS_FRAC = 8'h06;
  localparam logic [7:0] OFS_SETTINGS = 8'h20;
  localparam logic [7:0] OFS_BASE = 8'h22;
  localparam logic [7:0] OFS_FILTER = 8'h23;

  localparam logic [7:0] RST_ALARM_TWO = 8'h00;
  localparam logic [7:0] RST_SETTINGS = 8'h5d;
  localparam logic [7:0] RST_BASE = 8'h05;
  localparam logic [7:0] RST_FILTER = 8'h50;

  localparam logic [7:0] MASK_SETTINGS = 8'hff;
  localparam logic [7:0] MASK_BASE = 8'h0f;
  localparam logic [7:0] MASK_FILTER = 8'hfd;

  localparam int unsigned SPIN_LSB = 0;
  localparam int unsigned FREQ_LSB = 3;
  localparam int unsigned RANGE_LSB = 6;
  localparam int unsigned SPEED_LSB = 0;
  localparam int unsigned SPIN_OFF_BIT = 7;
  localparam int unsigned RAMP_LSB = 5;
  localparam int unsigned ADC_LSB = 2;
  localparam int unsigned FILT_BIT = 0;
  localparam int unsigned LOC_THERM_BIT = 6;
  localparam int unsigned THERM_PIN_BIT = 7;
  localparam int unsigned REM_FRAC_LSB = 0;
  localparam int unsigned LOC_FRAC_LSB = 6;

  localparam logic [3:0] DUTY_FULL = 4'hf;
  localparam logic [3:0] DUTY_SLOTS = 4'hf;
  localparam logic [3:0] FILT_HOLD = 4'h4;

  function automatic logic [13:0] spin_ms(input logic [2:0] code);
    case (code)
      3'h0: spin_ms = 14'h00c8;
      3'h1: spin_ms = 14'h0190;
      3'h2: spin_ms = 14'h0258;
      3'h3: spin_ms = 14'h0320;
      3'h4: spin_ms = 14'h03e8;
      3'h5: spin_ms = 14'h07d0;
      3'h6: spin_ms = 14'h0fa0;
      default: spin_ms = 14'h1f40;
    endcase
  endfunction : spin_ms

  // cycles per duty slot; frequencies held in hundredths of a hertz
  function automatic logic [31:0] slot_cycles(input int unsigned clk_hz,
                                              input logic [2:0] code);
    logic [63:0] chz;
    logic [63:0] q;
    case (code)
      3'h0: chz = 64'h492;
      3'h1: chz = 64'h618;
      3'h2: chz = 64'h924;
      3'h3: chz = 64'hc35;
      3'h4: chz = 64'hea6;
      3'h5: chz = 64'h1252;
      3'h6: chz = 64'h186a;
      default: chz = 64'h2486;
    endcase
    q = (64'(clk_hz) * 64'h64) / (chz * 64'(DUTY_SLOTS));
    slot_cycles = (q == 64'h0) ? 32'h1 : q[31:0];
  endfunction : slot_cycles

  function automatic logic [11:0] fail_rpm(input logic [1:0] code);
    case (code)
      2'h0: fail_rpm = 12'ha57;
      2'h1: fail_rpm = 12'h52c;
      2'h2: fail_rpm = 12'h296;
      default: fail_rpm = 12'h14b;
    endcase
  endfunction : fail_rpm
endpackage : fdcs_pkg

//--- rtl/fdcs_pwm.sv
// drive generator: 15-slot duty frame, ramped duty, optional glitch filter
// assumes target and codes are stable register fields
`timescale 1ns/10ps
module fdcs_pwm #(
  parameter int unsigned CLK_HZ = fdcs_pkg::CLK_RATE_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  fdcs_drive_if.pwm pw
);
  logic [31:0] cnt_ff, nxt_cnt_ff;
  logic [3:0] slot_ff, nxt_slot_ff;
  logic [3:0] duty_ff, nxt_duty_ff;
  logic out_ff, nxt_out_ff;
  logic [3:0] hold_ff, nxt_hold_ff;
  logic [31:0] slot_len;
  logic pend;
  logic raw;
  logic [4:0] step;
  logic [4:0] up;

  assign slot_len = fdcs_pkg::slot_cycles(CLK_HZ, pw.freq_code);
  assign pend = (cnt_ff >= slot_len - 32'h1) && (slot_ff >= fdcs_pkg::DUTY_SLOTS - 4'h1);
  assign raw = slot_ff < duty_ff;
  assign step = 5'h1 << pw.ramp_code;
  assign up = {1'b0, duty_ff} + step;
  assign pw.drive = out_ff;

  always_comb begin
    nxt_cnt_ff = cnt_ff;
    nxt_slot_ff = slot_ff;
    nxt_duty_ff = duty_ff;
    nxt_out_ff = out_ff;
    nxt_hold_ff = hold_ff;
    if (ce) begin
      if (cnt_ff >= slot_len - 32'h1) begin
        nxt_cnt_ff = 32'h0;
        nxt_slot_ff = pend ? 4'h0 : slot_ff + 4'h1;
      end else begin
        nxt_cnt_ff = cnt_ff + 32'h1;
      end
      // full drive bypasses the ramp so a hot fan reacts at once
      if (pw.full_speed) begin
        nxt_duty_ff = fdcs_pkg::DUTY_FULL;
      end else if (pend && duty_ff < pw.target) begin
        nxt_duty_ff = (up > {1'b0, pw.target}) ? pw.target : up[3:0];
      end else if (pend && duty_ff > pw.target) begin
        nxt_duty_ff = ({1'b0, duty_ff - pw.target} <= step) ? pw.target :
                      duty_ff - step[3:0];
      end
      // filter trades a few cycles of edge delay for glitch immunity
      if (!pw.filt_en || raw == out_ff) begin
        nxt_out_ff = raw;
        nxt_hold_ff = 4'h0;
      end else if (hold_ff >= fdcs_pkg::FILT_HOLD - 4'h1) begin
        nxt_out_ff = raw;
        nxt_hold_ff = 4'h0;
      end else begin
        nxt_hold_ff = hold_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      slot_ff <= 4'h0;
      duty_ff <= 4'h0;
      out_ff <= 1'b0;
      hold_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt_ff;
      slot_ff <= nxt_slot_ff;
      duty_ff <= nxt_duty_ff;
      out_ff <= nxt_out_ff;
      hold_ff <= nxt_hold_ff;
    end
  end

  chk_full_duty: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && pw.full_speed |=> duty_ff == fdcs_pkg::DUTY_FULL)
    else $error("full drive request did not force full duty");
  chk_ramp_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && pend && !pw.full_speed && duty_ff < pw.target
    |=> ({1'b0, duty_ff} - {1'b0, $past(duty_ff)}) <= $past(step))
    else $error("duty rose faster than the ramp step");
  chk_no_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && !pw.filt_en |=> out_ff == $past(raw))
    else $error("drive output delayed with filtering off");
endmodule : fdcs_pwm

//--- rtl/fdcs_spinup.sv
// kick-start timer: holds full drive for the selected duration
// assumes start is a one-cycle pulse from the register logic
`timescale 1ns/10ps
module fdcs_spinup #(
  parameter int unsigned CLK_HZ = fdcs_pkg::CLK_RATE_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  fdcs_drive_if.spin sp
);
  localparam int unsigned MS_CYC_RAW = CLK_HZ / fdcs_pkg::MS_PER_S;
  localparam logic [31:0] MS_CYC = (MS_CYC_RAW < 1) ? 32'h1 : 32'(MS_CYC_RAW);

  typedef enum logic {SP_IDLE, SP_RUN} fdcs_spin_t;
  fdcs_spin_t state_ff, nxt_state_ff;
  logic [31:0] tick_ff, nxt_tick_ff;
  logic [13:0] ms_ff, nxt_ms_ff;
  logic [13:0] dur;

  assign dur = fdcs_pkg::spin_ms(sp.spin_code);
  assign sp.spin_active = (state_ff == SP_RUN);

  always_comb begin
    nxt_state_ff = state_ff;
    nxt_tick_ff = tick_ff;
    nxt_ms_ff = ms_ff;
    if (ce) begin
      unique case (state_ff)
        SP_IDLE: begin
          if (sp.spin_start && !sp.spin_bypass) begin
            nxt_state_ff = SP_RUN;
            nxt_tick_ff = 32'h0;
            nxt_ms_ff = 14'h0;
          end
        end
        SP_RUN: begin
          if (sp.spin_bypass) begin
            nxt_state_ff = SP_IDLE;
          end else if (tick_ff >= MS_CYC - 32'h1) begin
            nxt_tick_ff = 32'h0;
            if (ms_ff >= dur - 14'h1) begin
              nxt_state_ff = SP_IDLE;
            end else begin
              nxt_ms_ff = ms_ff + 14'h1;
            end
          end else begin
            nxt_tick_ff = tick_ff + 32'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= SP_IDLE;
      tick_ff <= 32'h0;
      ms_ff <= 14'h0;
    end else begin
      state_ff <= nxt_state_ff;
      tick_ff <= nxt_tick_ff;
      ms_ff <= nxt_ms_ff;
    end
  end

  chk_spin_bypass: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && sp.spin_bypass |=> state_ff == SP_IDLE)
    else $error("spin-up kept running while bypassed");
  chk_spin_length: assert property (@(posedge core_clk) disable iff (!rst_n)
    // a code written mid-run shorter than the time already run ends the run at the next millisecond tick
    state_ff == SP_RUN |-> ms_ff < dur || $changed(sp.spin_code))
    else $error("spin-up ran past its selected duration");
endmodule : fdcs_spinup

//--- rtl/fdcs_top.sv
// fan drive settings, second alarm status and fraction readback
// assumes an upstream management-bus decoder gives one-cycle register
// strobes; every input is synchronous to core_clk
`timescale 1ns/10ps

module fdcs_top #(
  parameter int unsigned CLK_HZ = fdcs_pkg::CLK_RATE_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic therm_in_n,
  input wire logic loc_over_limit,
  input wire logic [2:0] remote_frac,
  input wire logic [1:0] local_frac,
  input wire logic automatic_control_select,
  input wire logic [3:0] auto_duty,
  output logic fan_drive,
  output logic spinup_active,
  output logic [3:0] tach_divisor,
  output logic [11:0] fail_rpm,
  output logic [2:0] adc_rate_code
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] settings_ff, nxt_settings_ff;
  logic [7:0] base_ff, nxt_base_ff;
  logic [7:0] filter_ff, nxt_filter_ff;
  logic [7:0] alarm_ff, nxt_alarm_ff;
  logic [7:0] rdata_ff, nxt_rdata_ff;
  logic blk_ff, nxt_blk_ff;
  logic nz_ff, nxt_nz_ff;

  logic rd_alarm;
  logic loc_set;
  logic [7:0] frac_val;
  logic [3:0] speed_nib;
  logic [3:0] tgt;

  fdcs_drive_if dr ();

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign rd_alarm = reg_rd && (reg_addr == fdcs_pkg::OFS_ALARM_TWO);
  // a condition that persists past a read must not re-raise the flag
  assign loc_set = loc_over_limit && !blk_ff;

  always_comb begin
    frac_val = 8'h00;
    frac_val[fdcs_pkg::REM_FRAC_LSB +: 3] = remote_frac;
    frac_val[fdcs_pkg::LOC_FRAC_LSB +: 2] = local_frac;
  end

  assign speed_nib = base_ff[fdcs_pkg::SPEED_LSB +: 4];

  // in automatic mode the nibble is a floor under the loop's demand
  always_comb begin
    if (automatic_control_select && auto_duty > speed_nib) begin
      tgt = auto_duty;
    end else begin
      tgt = speed_nib;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values

  always_comb begin
    nxt_settings_ff = settings_ff;
    nxt_base_ff = base_ff;
    nxt_filter_ff = filter_ff;
    nxt_alarm_ff = alarm_ff;
    nxt_rdata_ff = rdata_ff;
    nxt_blk_ff = blk_ff;
    nxt_nz_ff = nz_ff;
    if (ce) begin
      if (reg_wr) begin
        case (reg_addr)
          fdcs_pkg::OFS_SETTINGS: begin
            nxt_settings_ff = reg_wdata & fdcs_pkg::MASK_SETTINGS;
          end
          fdcs_pkg::OFS_BASE: begin
            nxt_base_ff = reg_wdata & fdcs_pkg::MASK_BASE;
          end
          fdcs_pkg::OFS_FILTER: begin
            nxt_filter_ff = reg_wdata & fdcs_pkg::MASK_FILTER;
          end
          default: begin
            nxt_settings_ff = settings_ff;
          end
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          fdcs_pkg::OFS_ALARM_TWO: nxt_rdata_ff = alarm_ff;
          fdcs_pkg::OFS_FRAC: nxt_rdata_ff = frac_val;
          fdcs_pkg::OFS_SETTINGS: nxt_rdata_ff = settings_ff;
          fdcs_pkg::OFS_BASE: nxt_rdata_ff = base_ff;
          fdcs_pkg::OFS_FILTER: nxt_rdata_ff = filter_ff;
          default: nxt_rdata_ff = 8'h00;
        endcase
      end
      // a new event in the reading cycle wins over the clear
      nxt_alarm_ff = 8'h00;
      nxt_alarm_ff[fdcs_pkg::LOC_THERM_BIT] = loc_set ||
        (alarm_ff[fdcs_pkg::LOC_THERM_BIT] && !rd_alarm);
      nxt_alarm_ff[fdcs_pkg::THERM_PIN_BIT] = !therm_in_n ||
        (alarm_ff[fdcs_pkg::THERM_PIN_BIT] && !rd_alarm);
      nxt_blk_ff = loc_over_limit;
      nxt_nz_ff = (tgt != 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      settings_ff <= fdcs_pkg::RST_SETTINGS;
      base_ff <= fdcs_pkg::RST_BASE;
      filter_ff <= fdcs_pkg::RST_FILTER;
      alarm_ff <= fdcs_pkg::RST_ALARM_TWO;
      rdata_ff <= 8'h00;
      blk_ff <= 1'b0;
      nz_ff <= 1'b0;
    end else begin
      settings_ff <= nxt_settings_ff;
      base_ff <= nxt_base_ff;
      filter_ff <= nxt_filter_ff;
      alarm_ff <= nxt_alarm_ff;
      rdata_ff <= nxt_rdata_ff;
      blk_ff <= nxt_blk_ff;
      nz_ff <= nxt_nz_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive control

  // kick-start fires whenever demand leaves zero, including after reset
  assign dr.spin_start = ce && (tgt != 4'h0) && !nz_ff;
  assign dr.spin_bypass = filter_ff[fdcs_pkg::SPIN_OFF_BIT];
  assign dr.spin_code = settings_ff[fdcs_pkg::SPIN_LSB +: 3];
  assign dr.target = tgt;
  assign dr.full_speed = !therm_in_n || dr.spin_active;
  assign dr.freq_code = settings_ff[fdcs_pkg::FREQ_LSB +: 3];
  assign dr.ramp_code = filter_ff[fdcs_pkg::RAMP_LSB +: 2];
  assign dr.filt_en = filter_ff[fdcs_pkg::FILT_BIT];

  fdcs_spinup #(
    .CLK_HZ(CLK_HZ)
  ) u_spinup (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .sp(dr.spin)
  );

  fdcs_pwm #(
    .CLK_HZ(CLK_HZ)
  ) u_pwm (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .pw(dr.pwm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = rdata_ff;
  assign fan_drive = dr.drive;
  assign spinup_active = dr.spin_active;
  assign tach_divisor = 4'h1 << settings_ff[fdcs_pkg::RANGE_LSB +: 2];
  assign fail_rpm = fdcs_pkg::fail_rpm(settings_ff[fdcs_pkg::RANGE_LSB +: 2]);
  assign adc_rate_code = filter_ff[fdcs_pkg::ADC_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_loc_once_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && loc_over_limit && !blk_ff |=> alarm_ff[fdcs_pkg::LOC_THERM_BIT])
    else $error("local over-limit did not raise its flag");
  chk_loc_no_reassert: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && loc_over_limit && blk_ff && !alarm_ff[fdcs_pkg::LOC_THERM_BIT]
    |=> !alarm_ff[fdcs_pkg::LOC_THERM_BIT])
    else $error("local flag reasserted during one episode");
  chk_therm_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && !therm_in_n |=> alarm_ff[fdcs_pkg::THERM_PIN_BIT])
    else $error("pin low did not raise its flag");
  chk_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && rd_alarm && therm_in_n && (!loc_over_limit || blk_ff)
    |=> alarm_ff == 8'h00 && reg_rdata == $past(alarm_ff))
    else $error("status read did not return then clear the flags");
  chk_therm_full: assert property (@(posedge core_clk) disable iff (!rst_n)
    !therm_in_n |-> dr.full_speed)
    else $error("pin low without full drive request");
  chk_status_reset: assert property (@(posedge core_clk)
    !rst_n |=> alarm_ff == 8'h00 && reg_rdata == 8'h00)
    else $error("status not zero after reset");
  chk_frac_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && reg_rd && reg_addr == fdcs_pkg::OFS_FRAC
    |=> reg_rdata == {$past(local_frac), 3'h0, $past(remote_frac)})
    else $error("fraction readback layout wrong");
  chk_base_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == fdcs_pkg::OFS_BASE
    |=> base_ff == ($past(reg_wdata) & fdcs_pkg::MASK_BASE))
    else $error("speed register write not masked");
  chk_auto_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
    (automatic_control_select |-> tgt >= speed_nib) and
    (!automatic_control_select |-> tgt == speed_nib))
    else $error("duty target ignores control mode");
  chk_divisor: assert property (@(posedge core_clk) disable iff (!rst_n)
    settings_ff[7:6] == 2'h3 |-> tach_divisor == 4'h8 && fail_rpm == 12'h14b)
    else $error("range code three gives wrong divisor");
endmodule : fdcs_top

//--- verif/fdcs_fan_model.sv
// behavioural fan on the drive output: integrates on-time like a real rotor
// assumes drive is registered on the rising edge of core_clk
`timescale 1ns/10ps
module fdcs_fan_model (
  input wire logic core_clk,
  input wire logic drive,
  output logic [31:0] on_cycles
);
  // only the on-time reaches the rotor, so a running count is all the bench needs
  initial on_cycles = 32'h0;
  always @(posedge core_clk) begin
    if (drive === 1'b1) begin
      on_cycles <= on_cycles + 32'h1;
    end
  end
endmodule : fdcs_fan_model

//--- verif/fdcs_top_tb_top.sv
// self-checking bench for fan drive settings, second status and fractions
// assumes a 1 kHz core rate parameter: one cycle per ms, 5-cycle slots at code 000
`timescale 1ns/10ps
module fdcs_top_tb_top;
  localparam int unsigned HZ = 32'h3e8;
  logic core_clk, rst_n, ce, reg_wr, reg_rd, therm_in_n, loc_over_limit;
  logic automatic_control_select, fan_drive, spinup_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] remote_frac, adc_rate_code;
  logic [1:0] local_frac;
  logic [3:0] auto_duty, tach_divisor;
  logic [11:0] fail_rpm;
  logic [31:0] on_cycles;
  int num_errors = 0;
  int cmp_count = 0;

  fdcs_top #(.CLK_HZ(HZ)) i_fdcs_top (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .therm_in_n(therm_in_n), .loc_over_limit(loc_over_limit),
    .remote_frac(remote_frac), .local_frac(local_frac),
    .automatic_control_select(automatic_control_select), .auto_duty(auto_duty),
    .fan_drive(fan_drive), .spinup_active(spinup_active), .tach_divisor(tach_divisor),
    .fail_rpm(fail_rpm), .adc_rate_code(adc_rate_code));
  fdcs_fan_model i_fdcs_fan_model (.core_clk(core_clk), .drive(fan_drive),
    .on_cycles(on_cycles));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_ms(input int c);
    logic [31:0] t [8] = '{32'hc8, 32'h190, 32'h258, 32'h320, 32'h3e8, 32'h7d0,
                           32'hfa0, 32'h1f40};
    return t[c];
  endfunction : exp_ms

  function automatic logic [31:0] exp_rpm(input int c);
    logic [31:0] t [4] = '{32'ha57, 32'h52c, 32'h296, 32'h14b};
    return t[c];
  endfunction : exp_rpm

  function automatic logic [7:0] mask_of(input logic [7:0] a);
    return (a == 8'h20) ? 8'hff : (a == 8'h22) ? 8'h0f : 8'hfd;
  endfunction : mask_of

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t register got %h want %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t value got %0d want %0d", $time, got, exp);
    end
  endtask : check_val

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check_reg(reg_rdata, exp);
  endtask : rd_chk

  task automatic measure(input int span, output logic [31:0] h);
    logic [31:0] s;
    s = on_cycles;
    cyc(span);
    h = on_cycles - s;
  endtask : measure

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(32'hea60);
    num_errors++;
    $display("unexpected %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    logic [7:0] a, d, n;
    logic [31:0] h, prev;
    int k, t;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    therm_in_n = 1'b1;
    loc_over_limit = 1'b0;
    remote_frac = 3'h0;
    local_frac = 2'h0;
    automatic_control_select = 1'b0;
    auto_duty = 4'h0;
    void'($urandom(32'ha27978c8));
    cyc(32'hc);
    rst_n = 1'b1;
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h20, 8'h5d);
    rd_chk(8'h22, 8'h05);
    rd_chk(8'h23, 8'h50);
    check_val(32'(tach_divisor), 32'h2);
    check_val(32'(fail_rpm), 32'h52c);
    check_val(32'(adc_rate_code), 32'h4);
    check_val(32'(spinup_active), 32'h1);
    wr(8'h23, 8'h80);
    cyc(32'h1);
    check_val(32'(spinup_active), 32'h0);
    $display("test reset and abort done");
    for (k = 0; k < 12; k++) begin
      a = (k % 3 == 0) ? 8'h20 : (k % 3 == 1) ? 8'h22 : 8'h23;
      d = 8'($urandom);
      wr(a, d);
      rd_chk(a, d & mask_of(a));
    end
    wr(8'h03, 8'hff);
    rd_chk(8'h03, 8'h00);
    wr(8'h55, 8'hff);
    rd_chk(8'h55, 8'h00);
    for (k = 0; k < 4; k++) begin
      remote_frac = 3'($urandom);
      local_frac = 2'($urandom);
      wr(8'h06, 8'hff);
      rd_chk(8'h06, {local_frac, 3'h0, remote_frac});
    end
    for (k = 0; k < 4; k++) begin
      wr(8'h20, {k[1:0], 6'h00});
      check_val(32'(tach_divisor), 32'h1 << k);
      check_val(32'(fail_rpm), exp_rpm(k));
    end
    for (k = 0; k < 8; k++) begin
      wr(8'h23, {3'h4, k[2:0], 2'h0});
      check_val(32'(adc_rate_code), 32'(k));
    end
    $display("test register map done");
    loc_over_limit = 1'b1;
    cyc(32'h2);
    rd_chk(8'h03, 8'h40);
    rd_chk(8'h03, 8'h00);
    loc_over_limit = 1'b0;
    cyc(32'h2);
    loc_over_limit = 1'b1;
    cyc(32'h2);
    rd_chk(8'h03, 8'h40);
    loc_over_limit = 1'b0;
    therm_in_n = 1'b0;
    cyc(32'h3);
    therm_in_n = 1'b1;
    cyc(32'h2);
    rd_chk(8'h03, 8'h80);
    rd_chk(8'h03, 8'h00);
    $display("test status flags done");
    // frequency code 000 gives 5-cycle slots, so a 75-cycle frame
    wr(8'h20, 8'h00);
    wr(8'h23, 8'he0);
    wr(8'h22, 8'h00);
    cyc(32'h12c);
    therm_in_n = 1'b0;
    cyc(32'h2);
    check_val(32'(fan_drive), 32'h1);
    measure(32'h2ee, h);
    check_val(h, 32'h2ee);
    therm_in_n = 1'b1;
    rd_chk(8'h03, 8'h80);
    $display("test pin full speed done");
    for (k = 0; k < 4; k++) begin
      n = 8'($urandom_range(32'hf, 32'h1));
      d = 8'($urandom_range(32'hf, 32'h0));
      automatic_control_select = k[0];
      auto_duty = d[3:0];
      wr(8'h23, 8'he0 | 8'(k[1]));
      wr(8'h22, n);
      cyc(32'h12c);
      measure(32'h2ee, h);
      t = (k[0] && d > n) ? int'(d) : int'(n);
      check_val(h, 32'(t) * 32'h32);
    end
    automatic_control_select = 1'b0;
    $display("test duty done");
    // a faster step must reach full drive sooner, and only step 8 gets there in time
    prev = 32'h0;
    for (k = 0; k < 4; k++) begin
      wr(8'h23, 8'he0);
      wr(8'h22, 8'h00);
      cyc(32'h12c);
      wr(8'h23, 8'h80 | 8'(k << 5));
      wr(8'h22, 8'h0f);
      cyc(32'he0);
      measure(32'h96, h);
      if (k == 3) begin
        check_val(h, 32'h96);
      end else begin
        check_val(32'(h < 32'h96 && h > prev), 32'h1);
      end
      prev = h;
    end
    $display("test ramp done");
    wr(8'h23, 8'h00);
    for (k = 0; k < 8; k++) begin
      wr(8'h22, 8'h00);
      wr(8'h20, 8'(k));
      wr(8'h22, 8'h05);
      h = 32'h0;
      for (t = 0; t < 9000; t++) begin
        if (spinup_active === 1'b1) begin
          h++;
        end else if (h != 32'h0) begin
          break;
        end
        @(negedge core_clk);
      end
      check_val(h, exp_ms(k));
    end
    $display("test kick-start done");
    complete_run();
  end
endmodule : fdcs_top_tb_top
